/* tb/adc_front_model.sv */
// Track-and-hold and comparator model facing the sequencer
`timescale 1ns/1ns
`default_nettype none
module adc_front_model
(
   input wire logic clk_i,
   input wire logic track_i,
   input wire logic [15:0] ain_i,
   input wire logic [15:0] trial_code_i,
   output logic comparator_o
);
   logic [15:0] held_reg = 16'h0000; // Charge on the hold capacitor
   // Follow the input only while the switches are closed
   always @(posedge clk_i)
      if (track_i)
         held_reg <= ain_i;
   // A sample at or above the trial level keeps the bit
   assign comparator_o = (held_reg >= trial_code_i);
endmodule // adc_front_model
`default_nettype wire

/* tb/conv_seq_checker.sv */
// Port-level assertions for the conversion sequencer
`timescale 1ns/1ns
`default_nettype none
module conv_seq_checker
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic reset_i,
   input wire logic convert_start_n_i,
   input wire logic read_convert_select_i,
   input wire logic [15:0] trial_code_o,
   input wire logic [15:0] result_o,
   input wire logic result_oe_o,
   input wire logic conversion_done_n_o,
   input wire logic track_o,
   input wire logic powered_o,
   input wire logic reference_on_o
);
   // ************************************************************
   // Power mode seen at the convert edge
   // ************************************************************
   logic sel_reg; // Select level seen at the convert edge
   // Bench holds select steady around edges, so the pin level will do
   always @(posedge clk_i)
      if ($fell(track_o))
         sel_reg <= read_convert_select_i;

   // ************************************************************
   // Port-level properties
   // ************************************************************
   default clocking @(posedge clk_i); endclocking
   // Pin reset is not yet synchronised, so it disables the checks
   default disable iff (!rst_n_i || reset_i);

   // Bus stays released while the sample is tracked
   property p_trk_bus;
      track_o |-> !result_oe_o;
   endproperty
   a_trk_bus: assert property (p_trk_bus)
      else $error("bus on in track");

   // Bus only driven on a read edge after the done flag fell
   property p_bus_on;
      $rose(result_oe_o) |-> read_convert_select_i
         && !conversion_done_n_o;
   endproperty
   a_bus_on: assert property (p_bus_on)
      else $error("bad bus drive");

   // Search starts with only the top bit on trial
   property p_msb;
      $fell(track_o) |-> trial_code_o == 16'h8000;
   endproperty
   a_msb: assert property (p_msb)
      else $error("first trial wrong");

   // Hold to done within the 47-cycle ceiling
   property p_eoc;
      $fell(track_o) |-> ##[1:47] $fell(conversion_done_n_o);
   endproperty
   a_eoc: assert property (p_eoc)
      else $error("conversion too slow");

   // Core off after conversion, reference per latched select
   property p_pwr;
      $fell(conversion_done_n_o) |-> !powered_o
         && reference_on_o == !sel_reg;
   endproperty
   a_pwr: assert property (p_pwr)
      else $error("power mode wrong");

   // Result word holds still for four cycles once done is flagged
   property p_res;
      $fell(conversion_done_n_o) |=> $stable(result_o) [*4];
   endproperty
   a_res: assert property (p_res)
      else $error("result moved");

   // Tracking only starts with select low
   property p_acq;
      $rose(track_o) |-> !read_convert_select_i;
   endproperty
   a_acq: assert property (p_acq)
      else $error("acquire with select high");

   // A strobe held high leaves the bus released
   property p_rel;
      convert_start_n_i [*8] |-> !result_oe_o;
   endproperty
   a_rel: assert property (p_rel)
      else $error("bus not released");

   // A held reset pin forces the idle state
   property p_rst;
      disable iff (!rst_n_i)
      reset_i [*8] |-> !track_o && !result_oe_o
         && conversion_done_n_o;
   endproperty
   a_rst: assert property (p_rst)
      else $error("reset pin ignored");
endmodule // conv_seq_checker
`default_nettype wire

/* tb/conv_seq_tb.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ns
`default_nettype none
module conv_seq_tb;
   logic clk_i, rst_n_i, reset_i, start_n, sel, cmp;
   logic [15:0] ain, trial, res;
   wire oe, done_n, trk, pwr, ref_on;
   int checks = 0;
   int num_errors = 0;
   conv_seq DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .reset_i(reset_i),
      .convert_start_n_i(start_n), .read_convert_select_i(sel),
      .comparator_i(cmp), .trial_code_o(trial), .result_o(res),
      .result_oe_o(oe), .conversion_done_n_o(done_n), .track_o(trk),
      .powered_o(pwr), .reference_on_o(ref_on));
   adc_front_model front (.clk_i(clk_i), .track_i(trk), .ain_i(ain),
      .trial_code_i(trial), .comparator_o(cmp));
   task chk(input string name, input logic [15:0] seen, exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Strobe edges hold each level long enough for the synchronisers
   task fall(input logic s);
      sel = s;
      repeat (2) @(negedge clk_i);
      start_n = 1'b0;
      repeat (8) @(negedge clk_i);
   endtask
   task rise;
      start_n = 1'b1;
      repeat (8) @(negedge clk_i);
   endtask
   task t_conv(input logic [15:0] v, input logic m);
      int n;
      ain = v;
      fall(1'b0);
      chk("track", trk, 1);
      chk("powered", pwr, 1);
      rise;
      fall(m);
      ain = ~v; // Moving input must not reach the held sample
      n = 8;
      while (done_n === 1'b1 && n < 60)
      begin
         @(negedge clk_i);
         n++;
      end
      chk("eoc_time", n <= 47, 1);
      chk("result", res, v);
      chk("bus_idle", oe, 0);
      chk("ref_on", ref_on, !m);
      rise;
      fall(1'b0);
      chk("bus_sel_low", oe, 0);
      rise;
      fall(1'b1);
      chk("bus_on", oe, 1);
      chk("bus_data", res, v);
      rise;
      chk("bus_rel", oe, 0);
   endtask
   task t_ignore;
      fall(1'b1);
      chk("ign_track", trk, 0);
      chk("ign_power", pwr, 0);
      rise;
   endtask
   task t_reset;
      fall(1'b0);
      rise;
      reset_i = 1'b1; // Strobe stays high while the pin is pulsed
      repeat (10) @(negedge clk_i);
      reset_i = 1'b0;
      repeat (4) @(negedge clk_i);
      chk("rst_track", trk, 0);
      chk("rst_power", pwr, 0);
   endtask
   task summarize;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // Cut a hang short; a full run needs under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge clk_i);
      num_errors++;
      summarize;
   end
   initial
   begin
      {rst_n_i, reset_i, sel} = 3'b000;
      start_n = 1'b1;
      ain = 16'h0000;
      repeat (6) @(negedge clk_i);
      rst_n_i = 1'b1;
      t_ignore;
      t_conv(16'hA5C3, 1'b0);
      t_conv(16'h0001, 1'b1);
      // Shutdown is woken here by an acquire edge with no convert
      // edge after it, and the reset pin then returns it to idle
      t_reset;
      t_conv(16'hFFFF, 1'b0);
      t_conv(16'h8000, 1'b1);
      summarize;
   end
endmodule // conv_seq_tb
bind conv_seq conv_seq_checker chk_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .reset_i(reset_i), .convert_start_n_i(convert_start_n_i),
   .read_convert_select_i(read_convert_select_i),
   .trial_code_o(trial_code_o), .result_o(result_o),
   .result_oe_o(result_oe_o), .conversion_done_n_o(conversion_done_n_o),
   .track_o(track_o), .powered_o(powered_o),
   .reference_on_o(reference_on_o));
`default_nettype wire

/* verilog/conv_seq.v */
// Conversion sequencer for a 16-bit successive-approximation converter
`timescale 1ns/1ns
`default_nettype none
`include "conv_seq_regs.vh"

module conv_seq
(
   input wire clk_i, // 10 MHz clock
   input wire rst_n_i, // Synchronous reset, active low
   input wire reset_i, // Device reset pin, active high
   input wire convert_start_n_i, // Convert-start strobe, active low
   input wire read_convert_select_i, // Read/convert select
   input wire comparator_i, // Comparator: sample at or above trial level
   output wire [`RESULT_MSB:0] trial_code_o, // Trial code to the DAC
   output reg [`RESULT_MSB:0] result_o, // Result bus output data
   output reg result_oe_o, // Result bus drive enable
   output reg conversion_done_n_o, // Done flag, active low
   output reg track_o, // Track-and-hold switches closed
   output reg powered_o, // Converter core powered
   output reg reference_on_o // Reference and buffer powered
);

   // ************************************************************
   // Phase encoding
   // ************************************************************
   localparam [1:0] PH_ACQUIRE = 2'b00; // Waiting for acquire edge
   localparam [1:0] PH_CONVERT = 2'b01; // Waiting for convert edge
   localparam [1:0] PH_READ = 2'b10; // Waiting for read edge

   // ************************************************************
   // Input synchronisers
   // ************************************************************
   reg [2:0] cs_sync_reg; // Strobe synchroniser chain
   reg [2:0] sel_sync_reg; // Select synchroniser chain
   reg [2:0] rst_sync_reg; // Reset pin synchroniser chain
   reg cs_level_reg; // Debounced strobe level
   reg sel_level_reg; // Debounced select level
   reg dev_rst_reg; // Debounced device reset level
   wire cs_fall; // Strobe fell this cycle
   wire cs_rise; // Strobe rose this cycle

   // Three flops; a change counts once stages two and three agree
   // Strobe chain resets high, its idle level, so no false edge
   always @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         cs_sync_reg <= 3'h7;
         sel_sync_reg <= 3'h0;
         rst_sync_reg <= 3'h0;
         cs_level_reg <= 1'b1;
         sel_level_reg <= 1'b0;
         dev_rst_reg <= 1'b0;
      end
      else
      begin
         cs_sync_reg <= {cs_sync_reg[1:0], convert_start_n_i};
         sel_sync_reg <= {sel_sync_reg[1:0], read_convert_select_i};
         rst_sync_reg <= {rst_sync_reg[1:0], reset_i};
         if (cs_sync_reg[1] == cs_sync_reg[2])
            cs_level_reg <= cs_sync_reg[2];
         if (sel_sync_reg[1] == sel_sync_reg[2])
            sel_level_reg <= sel_sync_reg[2];
         if (rst_sync_reg[1] == rst_sync_reg[2])
            dev_rst_reg <= rst_sync_reg[2];
      end
   end

   // Edges taken from the debounced level, never the first flop
   assign cs_fall = cs_level_reg && (cs_sync_reg[1] == cs_sync_reg[2])
                    && !cs_sync_reg[2];
   assign cs_rise = !cs_level_reg && (cs_sync_reg[1] == cs_sync_reg[2])
                    && cs_sync_reg[2];

   // ************************************************************
   // Sequencer and successive approximation
   // ************************************************************
   reg [1:0] phase_reg; // Three-phase strobe counter
   reg shutdown_sel_reg; // Power mode latched at convert edge
   reg converting_reg; // Bit search in progress
   reg done_reg; // Result complete and readable
   reg [`BIT_PTR_WIDTH-1:0] bit_ptr_reg; // Bit under trial
   reg [`STEP_CNT_WIDTH-1:0] step_cnt_reg; // Internal clock divider
   reg [`RESULT_MSB:0] code_reg; // Bits decided so far
   reg [`RESULT_MSB:0] trial_reg; // Code being tried
   wire bit_step; // Internal conversion clock enable
   wire [3:0] bit_idx; // Bit pointer as a result index

   // One trial per two clocks: 16 bits in 32 cycles, under the
   // 47-cycle ceiling, leaving margin for edge sync latency
   // Strobe sync adds four clocks, so pin to done is 36 cycles
   // Compared against a sized constant so no bits are dropped
   assign bit_step = (step_cnt_reg == `BIT_STEP_LAST);
   assign bit_idx = bit_ptr_reg[3:0];
   assign trial_code_o = trial_reg;

   // Main sequencer; device reset pin has priority over strobes
   always @(posedge clk_i)
   begin
      if (!rst_n_i || dev_rst_reg)
      begin
         // All power off, bus released, done flag high
         // The reference starts off; the first acquire powers it up
         phase_reg <= PH_ACQUIRE;
         shutdown_sel_reg <= 1'b1;
         converting_reg <= 1'b0;
         done_reg <= 1'b0;
         bit_ptr_reg <= {`BIT_PTR_WIDTH{1'b0}};
         step_cnt_reg <= {`STEP_CNT_WIDTH{1'b0}};
         code_reg <= `RESULT_RESET;
         trial_reg <= `RESULT_RESET;
         result_o <= `RESULT_RESET;
         result_oe_o <= 1'b0;
         conversion_done_n_o <= 1'b1;
         track_o <= 1'b0;
         powered_o <= 1'b0;
         reference_on_o <= 1'b0;
      end
      else
      begin
         // Bit search runs on its own divided clock
         if (converting_reg)
         begin
            step_cnt_reg <= step_cnt_reg + 1'b1;
            if (bit_step)
            begin
               step_cnt_reg <= {`STEP_CNT_WIDTH{1'b0}};
               // Keep the trial bit if sample is at or above trial level
               if (comparator_i)
                  code_reg[bit_idx] <= 1'b1;
               if (bit_ptr_reg == {`BIT_PTR_WIDTH{1'b0}})
               begin
                  // Last bit decided: result is valid
                  converting_reg <= 1'b0;
                  done_reg <= 1'b1;
                  conversion_done_n_o <= 1'b0;
                  // Power mode chosen at convert edge
                  powered_o <= 1'b0;
                  reference_on_o <= !shutdown_sel_reg;
                  result_o <= comparator_i ?
                     (code_reg | trial_reg) : code_reg;
               end
               else
               begin
                  bit_ptr_reg <= bit_ptr_reg - 1'b1;
                  trial_reg <= (comparator_i ? (code_reg | trial_reg)
                     : code_reg) | (`RESULT_RESET + (16'h0001 <<
                     (bit_idx - 4'h1)));
               end
            end
         end
         // Strobe rise ends a read and releases the bus
         // A rise in any other phase changes nothing
         if (cs_rise && result_oe_o)
            result_oe_o <= 1'b0;
         if (cs_fall)
         begin
            case (phase_reg)
               PH_ACQUIRE:
               begin
                  // Select high ignores the edge, phase unchanged
                  if (!sel_level_reg)
                  begin
                     powered_o <= 1'b1;
                     reference_on_o <= 1'b1;
                     track_o <= 1'b1;
                     conversion_done_n_o <= 1'b1;
                     done_reg <= 1'b0;
                     result_oe_o <= 1'b0;
                     phase_reg <= PH_CONVERT;
                  end
               end
               PH_CONVERT:
               begin
                  track_o <= 1'b0;
                  shutdown_sel_reg <= sel_level_reg;
                  converting_reg <= 1'b1;
                  // Search starts at the most significant bit
                  bit_ptr_reg <= `MSB_PTR;
                  step_cnt_reg <= {`STEP_CNT_WIDTH{1'b0}};
                  // Fresh code; an earlier result must not leak in
                  code_reg <= `RESULT_RESET;
                  trial_reg <= `FIRST_TRIAL;
                  phase_reg <= PH_READ;
               end
               PH_READ:
               begin
                  // Read only honoured with select high after done
                  // Otherwise the phase keeps waiting for a read
                  if (sel_level_reg && done_reg)
                  begin
                     result_oe_o <= 1'b1;
                     phase_reg <= PH_ACQUIRE;
                  end
               end
               // Unused code: fall back to acquire
               default:
                  phase_reg <= PH_ACQUIRE;
            endcase
         end
      end
   end

endmodule // conv_seq
`default_nettype wire

/* verilog/conv_seq_regs.vh */
// Constants for the parallel-result conversion sequencer
`ifndef CONV_SEQ_REGS_VH
`define CONV_SEQ_REGS_VH
// Result width in bits
`define RESULT_WIDTH 16
// Bit index of the result's most significant bit
`define RESULT_MSB 15
// Width of the bit pointer used by the successive approximation
`define BIT_PTR_WIDTH 5
// Clock period in nanoseconds
`define CLK_PERIOD_NS 100
// Longest conversion time in nanoseconds
`define CONV_MAX_NS 4700
// Longest conversion time in clock cycles, rounded down
`define CONV_MAX_CYCLES (`CONV_MAX_NS / `CLK_PERIOD_NS)
// Cycles between successive-approximation bit trials
`define BIT_STEP_CYCLES 2
// Width of the bit-step divider
`define STEP_CNT_WIDTH 2
// Last count of the bit-step divider, sized to the divider
`define BIT_STEP_LAST 2'h1
// Bit pointer value of the most significant bit
`define MSB_PTR 5'h0F
// First trial code: only the most significant bit set
`define FIRST_TRIAL 16'h8000
// Reset value of the result register
`define RESULT_RESET 16'h0000
`endif
